// file: rtl/brd_rop_dim.sv
// Summary of operation
// RQ1 - width register holds 12-bit rectangle width
// RQ2 - software triples width in packed 24-bit mode
// RQ3 - line command: width is major extent plus one
// RQ4 - short stroke: width is horizontal stroke length
// RQ5 - top control bit picks three or two operands
// RQ6 - bit 14 picks pattern or source, two-operand
// RQ7 - bit 11 repeats rotation only on rotation command
// RQ8 - bit 10 makes matching pixels opaque or transparent
// RQ9 - bit 8 enables transparency, bit 9 picks operand
// RQ10 - low byte code; two-operand uses bits 3:0
// RQ11 - three-operand result bit indexed pattern,source,destination
// RQ12 - two-operand result bit indexed source,destination
// RQ13 - command field selects width interpretation
// RQ14 - operation applied independently on every pixel bit
`timescale 1ns/10ps
`default_nettype none
module brd_rop_dim #(
  parameter int PIX_W = 32                      // pixel width in bits
) (
  input  wire logic                    clk_sys,      // 50 MHz engine clock
  input  wire logic                    rstn,         // async reset, active low
  input  wire logic                    reg_wr,       // register write strobe
  input  wire logic                    reg_rd,       // register read strobe
  input  wire logic [7:0]              reg_addr,     // byte offset from engine base
  input  wire logic [15:0]             reg_wdata,    // write data
  output logic      [15:0]             reg_rdata,    // read data, one cycle after reg_rd
  input  wire logic [3:0]              cmd_func,     // command field of engine_command_control
  input  wire logic                    op_valid,     // pixel operands present
  input  wire logic [PIX_W-1:0]        pat_pix,      // pattern pixel
  input  wire logic [PIX_W-1:0]        src_pix,      // source pixel
  input  wire logic [PIX_W-1:0]        dst_pix,      // destination pixel
  input  wire logic [PIX_W-1:0]        key_color,    // transparency compare colour
  output logic                         res_valid,    // result present, one cycle after op_valid
  output logic      [PIX_W-1:0]        res_pix,      // raster-op result
  output logic                         res_we,       // result is to be written
  output logic      [brd_pkg::WIDTH_BITS-1:0] rect_width,   // width for block and fill
  output logic      [brd_pkg::WIDTH_BITS-1:0] vector_len,   // length for line command
  output logic      [brd_pkg::WIDTH_BITS-1:0] stroke_len,   // length for horizontal stroke
  output logic                         repeat_rot    // repeated rotation transfer active
);
  import brd_pkg::*;

  // whole module state; every flop sits in this one struct so the reset
  // branch and the next-state copy can never drift apart
  typedef struct packed {
    logic [WIDTH_BITS-1:0] width_reg;   // width_or_vector_length
    logic [15:0]           ctrl_reg;    // raster_op_misc_control
    logic [15:0]           rdata;       // read data register
    logic                  valid;       // result valid
    logic [PIX_W-1:0]      res;         // result pixel
    logic                  we;          // write enable of result
    logic [WIDTH_BITS-1:0] rect;        // decoded rectangle width
    logic [WIDTH_BITS-1:0] vlen;        // decoded vector length
    logic [WIDTH_BITS-1:0] slen;        // decoded stroke length
    logic                  rrot;        // repeat rotation active
  } brd_state_s;

  brd_state_s st_reg;   // registered state
  brd_state_s st_next;  // next state

  // combinational helpers feeding the next-state logic
  logic [PIX_W-1:0] rop_bits;  // per-bit raster-op result
  logic             two_op;    // two-operand mode selected
  logic             match;     // compared operand equals key colour

  assign two_op = st_reg.ctrl_reg[ROP_TYPE_BIT];  // RQ5

  // one lookup per pixel bit; no carries run between bits
  for (genvar i = 0; i < PIX_W; i++) begin : g_rop  // RQ14
    logic opnd2;  // second operand of two-operand op
    assign opnd2 = st_reg.ctrl_reg[ROP2_SRC_BIT] ? pat_pix[i] : src_pix[i];  // RQ6
    // three-operand uses the full byte, two-operand only bits 3:0
    assign rop_bits[i] = two_op ? st_reg.ctrl_reg[{opnd2, dst_pix[i]}]        // RQ12 RQ10
                                : st_reg.ctrl_reg[{pat_pix[i], src_pix[i], dst_pix[i]}];  // RQ11 RQ10
  end

  // transparency compares either the source or the destination pixel
  // a full-width compare: a key that differs in any bit never matches
  assign match = (st_reg.ctrl_reg[TRANSP_OPND_BIT] ? dst_pix : src_pix) == key_color;  // RQ9

  // next-state logic; a register write is visible in the state right
  // after the edge that samples it, so a read one cycle later sees it
  always_comb begin
    st_next = st_reg;
    // register writes; reserved width bits are not stored and read zero
    if (reg_wr) begin
      if (reg_addr == WIDTH_OFS) begin
        st_next.width_reg = reg_wdata[WIDTH_BITS-1:0];  // RQ1
      end
      if (reg_addr == ROP_CTRL_OFS) begin
        st_next.ctrl_reg = reg_wdata;
      end
    end
    // read data; unmapped offsets read a fixed value
    if (reg_rd) begin
      unique case (reg_addr)
        WIDTH_OFS:    st_next.rdata = {4'h0, st_reg.width_reg};  // RQ1
        ROP_CTRL_OFS: st_next.rdata = st_reg.ctrl_reg;
        default:      st_next.rdata = UNMAPPED_DATA;
      endcase
    end
    // pixel result; a matching pixel is dropped only with mpc set
    st_next.valid = op_valid;
    if (op_valid) begin
      st_next.res = rop_bits;
      st_next.we  = !(st_reg.ctrl_reg[TRANSP_EN_BIT] && st_reg.ctrl_reg[MATCH_CTRL_BIT] && match);  // RQ8 RQ9
    end
    // width interpretation follows the command field; others read zero
    st_next.rect = st_reg.width_reg;                                                             // RQ1
    st_next.vlen = (cmd_func == CMD_LINE) ? st_reg.width_reg : '0;                               // RQ3 RQ13
    st_next.slen = (cmd_func == CMD_SHORT_STROKE) ? st_reg.width_reg : '0;                       // RQ4 RQ13
    st_next.rrot = st_reg.ctrl_reg[REPEAT_ROT_BIT] && (cmd_func == CMD_ROT_BLT);                 // RQ7 RQ13
  end

  // state register
  // reset values are zero apart from the write flag, which idles high so
  // a pixel never looks dropped before the first operand arrives
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg           <= '0;
      st_reg.width_reg <= WIDTH_RESET;
      st_reg.ctrl_reg  <= ROP_CTRL_RESET;
      st_reg.we        <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  // no logic between flop and pin, so downstream timing sees clean flops
  assign reg_rdata  = st_reg.rdata;
  assign res_valid  = st_reg.valid;
  assign res_pix    = st_reg.res;
  assign res_we     = st_reg.we;
  assign rect_width = st_reg.rect;
  assign vector_len = st_reg.vlen;
  assign stroke_len = st_reg.slen;
  assign repeat_rot = st_reg.rrot;

  // checks below share one clock and are muted while reset is low
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // write of the width register followed by a read
  sequence seq_width_wr;
    reg_wr && reg_addr == WIDTH_OFS && !reg_rd;
  endsequence
  sequence seq_width_rd;
    reg_rd && reg_addr == WIDTH_OFS && !reg_wr;
  endsequence

  chk_width_readback: assert property (seq_width_wr ##1 seq_width_rd |=> reg_rdata == {4'h0, $past(reg_wdata[11:0], 2)})  // RQ1
    else $error("width register readback wrong");
  chk_line_length: assert property (cmd_func == CMD_LINE ##1 cmd_func == CMD_LINE |-> vector_len == rect_width && stroke_len == '0)  // RQ3
    else $error("vector length not taken from width");
  chk_stroke_length: assert property (cmd_func == CMD_SHORT_STROKE ##1 cmd_func == CMD_SHORT_STROKE |-> stroke_len == rect_width && vector_len == '0)  // RQ4
    else $error("stroke length not taken from width");
  chk_repeat_rot_gate: assert property (cmd_func != CMD_ROT_BLT |=> !repeat_rot)  // RQ7
    else $error("repeat rotation active without rotation command");
  chk_rop3_pattern: assert property (op_valid && !two_op && st_reg.ctrl_reg[7:0] == 8'hf0 |=> res_valid && res_pix == $past(pat_pix))  // RQ11
    else $error("three-operand pattern copy wrong");
  chk_rop3_dest: assert property (op_valid && !two_op && st_reg.ctrl_reg[7:0] == 8'haa |=> res_pix == $past(dst_pix))  // RQ11
    else $error("three-operand destination copy wrong");
  chk_rop2_xor: assert property (op_valid && two_op && !st_reg.ctrl_reg[ROP2_SRC_BIT] && st_reg.ctrl_reg[3:0] == 4'h6
                                 |=> res_pix == ($past(src_pix) ^ $past(dst_pix)))  // RQ12
    else $error("two-operand xor wrong");
  chk_rop2_pattern: assert property (op_valid && two_op && st_reg.ctrl_reg[ROP2_SRC_BIT] && st_reg.ctrl_reg[3:0] == 4'hc
                                     |=> res_pix == $past(pat_pix))  // RQ6
    else $error("two-operand pattern source wrong");
  chk_transp_drop: assert property (op_valid && st_reg.ctrl_reg[TRANSP_EN_BIT] && st_reg.ctrl_reg[MATCH_CTRL_BIT]
                                    && !st_reg.ctrl_reg[TRANSP_OPND_BIT] && src_pix == key_color |=> !res_we)  // RQ8
    else $error("matching pixel written while transparent");
  chk_transp_off: assert property (op_valid && !st_reg.ctrl_reg[TRANSP_EN_BIT] |=> res_we)  // RQ9
    else $error("pixel dropped with transparency off");

  // control word written and read back on consecutive cycles
  sequence seq_ctrl_wr;
    reg_wr && reg_addr == ROP_CTRL_OFS && !reg_rd;
  endsequence
  sequence seq_ctrl_rd;
    reg_rd && reg_addr == ROP_CTRL_OFS && !reg_wr;
  endsequence
  // a read of an offset that maps to nothing in this block
  sequence seq_unmapped_rd;
    reg_rd && reg_addr != WIDTH_OFS && reg_addr != ROP_CTRL_OFS;
  endsequence
  // a pixel taken in each operation type
  sequence seq_rop3_take;
    op_valid && !two_op;
  endsequence
  sequence seq_rop2_take;
    op_valid && two_op;
  endsequence
  // transparency armed so that a matching pixel is to be dropped
  sequence seq_drop_armed;
    op_valid && st_reg.ctrl_reg[TRANSP_EN_BIT] && st_reg.ctrl_reg[MATCH_CTRL_BIT];
  endsequence

  // register port answers
  chk_ctrl_readback: assert property (seq_ctrl_wr ##1 seq_ctrl_rd |=> reg_rdata == $past(reg_wdata, 2))  // RQ5
    else $error("control register readback wrong");
  chk_width_reserved: assert property (seq_width_rd |=> reg_rdata[15:WIDTH_BITS] == '0)  // RQ1
    else $error("reserved width bits read nonzero");
  chk_unmapped_read: assert property (seq_unmapped_rd |=> reg_rdata == UNMAPPED_DATA)  // RQ1
    else $error("unmapped offset read wrong");

  // lengths stay zero unless their own command is selected
  chk_vector_gate: assert property (cmd_func != CMD_LINE |=> vector_len == '0)  // RQ3
    else $error("vector length shown without line command");
  chk_stroke_gate: assert property (cmd_func != CMD_SHORT_STROKE |=> stroke_len == '0)  // RQ4
    else $error("stroke length shown without stroke command");

  // pixel path timing: exactly one result pulse per operand strobe
  chk_valid_pulse: assert property (op_valid |=> res_valid)  // RQ14
    else $error("result missing after operand strobe");
  chk_valid_idle: assert property (!op_valid |=> !res_valid)  // RQ14
    else $error("result pulse without operand strobe");

  // further lookup corners of both operation types
  chk_rop3_source: assert property (seq_rop3_take ##0 st_reg.ctrl_reg[7:0] == 8'hcc  // RQ11
                                    |=> res_pix == $past(src_pix))
    else $error("three-operand source copy wrong");
  chk_rop2_zero: assert property (seq_rop2_take ##0 st_reg.ctrl_reg[3:0] == 4'h0 |=> res_pix == '0)  // RQ12
    else $error("two-operand zero code wrong");
  chk_rop2_one: assert property (seq_rop2_take ##0 st_reg.ctrl_reg[3:0] == 4'hf |=> res_pix == '1)  // RQ12
    else $error("two-operand one code wrong");
  chk_rop2_dest: assert property (seq_rop2_take ##0 st_reg.ctrl_reg[3:0] == 4'ha  // RQ12
                                  |=> res_pix == $past(dst_pix))
    else $error("two-operand destination copy wrong");
  chk_rop2_rsvd_ignored: assert property (seq_rop2_take ##0 st_reg.ctrl_reg[7:4] != 4'h0  // RQ10
                                          ##0 !st_reg.ctrl_reg[ROP2_SRC_BIT] && st_reg.ctrl_reg[3:0] == 4'hc
                                          |=> res_pix == $past(src_pix))
    else $error("reserved bits disturb two-operand code");

  // transparency through the destination operand, and opaque matches
  chk_transp_dest: assert property (seq_drop_armed ##0 st_reg.ctrl_reg[TRANSP_OPND_BIT] && dst_pix == key_color  // RQ9
                                    |=> !res_we)
    else $error("matching destination pixel written while transparent");
  chk_match_opaque: assert property (op_valid && st_reg.ctrl_reg[TRANSP_EN_BIT]  // RQ8
                                     && !st_reg.ctrl_reg[MATCH_CTRL_BIT] |=> res_we)
    else $error("opaque matching pixel dropped");
endmodule
`default_nettype wire

// file: rtl/brd_pkg.sv
`default_nettype none
package brd_pkg;
  // register offsets on the engine register port (byte addresses)
  localparam logic [7:0]  WIDTH_OFS        = 8'h0a;
  localparam logic [7:0]  ROP_CTRL_OFS     = 8'h0c;
  // width register layout
  localparam int          WIDTH_BITS       = 12;
  localparam logic [11:0] WIDTH_RESET      = 12'h000;
  // raster-op control field positions
  localparam int          ROP_TYPE_BIT     = 15;
  localparam int          ROP2_SRC_BIT     = 14;
  localparam int          REPEAT_ROT_BIT   = 11;
  localparam int          MATCH_CTRL_BIT   = 10;
  localparam int          TRANSP_OPND_BIT  = 9;
  localparam int          TRANSP_EN_BIT    = 8;
  localparam logic [15:0] ROP_CTRL_RESET   = 16'h0000;
  // command field codes that change how the width register or the repeat rotation bit is read
  localparam logic [3:0]  CMD_SHORT_STROKE = 4'h6;
  localparam logic [3:0]  CMD_LINE         = 4'h7;
  localparam logic [3:0]  CMD_ROT_BLT      = 4'hb;
  // read data seen at an unmapped offset
  localparam logic [15:0] UNMAPPED_DATA    = 16'h0000;
endpackage
`default_nettype wire

// file: sim/brd_rop_dim_tb.sv
`timescale 1ns/10ps
`default_nettype none
// one comparison: counts it, reports a mismatch at once
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module brd_rop_dim_tb;
  import brd_pkg::*;
  // operands chosen so every p,s,d mix occurs in each byte of the upper half
  localparam logic [31:0] P = 32'hf0f0_ff00;
  localparam logic [31:0] S = 32'hcccc_f0f0;
  localparam logic [31:0] D = 32'haaaa_cccc;
  localparam logic [31:0] K = 32'h1234_5678;  // key that matches neither operand
  logic        clk_sys   = 1'b0;
  logic        rstn      = 1'b0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [3:0]  cmd_func  = 4'h0;
  logic        op_valid  = 1'b0;
  logic [31:0] key_color = K;
  logic [31:0] pat_pix   = P;
  logic [31:0] src_pix   = S;
  logic [31:0] dst_pix   = D;
  logic        res_valid;
  logic [31:0] res_pix;
  logic        res_we;
  logic [11:0] rect_width;
  logic [11:0] vector_len;
  logic [11:0] stroke_len;
  logic        repeat_rot;
  int          error_cnt = 0;
  int          n_checks  = 0;
  brd_rop_dim #(.PIX_W(32)) uut (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_func(cmd_func),
    .op_valid(op_valid), .pat_pix(pat_pix), .src_pix(src_pix), .dst_pix(dst_pix), .key_color(key_color),
    .res_valid(res_valid), .res_pix(res_pix), .res_we(res_we), .rect_width(rect_width),
    .vector_len(vector_len), .stroke_len(stroke_len), .repeat_rot(repeat_rot));
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  // expected result, worked bit by bit from the control word
  function automatic logic [31:0] rop_exp(input logic [15:0] c);
    logic [31:0] r;
    logic        s2;
    for (int i = 0; i < 32; i++) begin
      s2 = c[14] ? pat_pix[i] : src_pix[i];
      r[i] = c[15] ? c[{s2, dst_pix[i]}] : c[{pat_pix[i], src_pix[i], dst_pix[i]}];
    end
    return r;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys); #1;
    reg_wr = 1'b1; reg_addr = a; reg_wdata = v;
    @(posedge clk_sys); #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys); #1;
    reg_rd = 1'b1; reg_addr = a;
    @(posedge clk_sys); #1;
    reg_rd = 1'b0;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  // write, then read on the very next cycle, the tightest legal order
  task automatic wrrd(input logic [7:0] a, input logic [15:0] v, input logic [15:0] e);
    @(posedge clk_sys); #1;
    reg_wr = 1'b1; reg_addr = a; reg_wdata = v;
    @(posedge clk_sys); #1;
    reg_wr = 1'b0; reg_rd = 1'b1;
    @(posedge clk_sys); #1;
    reg_rd = 1'b0;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  // decoded lengths settle one cycle after the command field changes
  task automatic cmd(input logic [3:0] f, input logic [11:0] vl, input logic [11:0] sl, input logic rr);
    @(posedge clk_sys); #1;
    cmd_func = f;
    @(posedge clk_sys); #1;
    `CHK("vector_len", vl, vector_len)
    `CHK("stroke_len", sl, stroke_len)
    `CHK("repeat_rot", rr, repeat_rot)
  endtask
  // program the control word, push one pixel, check the registered result
  task automatic pixe(input logic [15:0] c, input logic [31:0] k, input logic [31:0] e, input logic we);
    wr(ROP_CTRL_OFS, c);
    @(posedge clk_sys); #1;
    key_color = k; op_valid = 1'b1;
    @(posedge clk_sys); #1;
    op_valid = 1'b0;
    `CHK("res_valid", 1'b1, res_valid)
    `CHK("res_pix", e, res_pix)
    `CHK("res_we", we, res_we)
    // the valid pulse lasts one cycle only
    @(posedge clk_sys); #1;
    `CHK("res_valid", 1'b0, res_valid)
  endtask
  // same, with the result worked out bit by bit from the control word
  task automatic pix(input logic [15:0] c, input logic [31:0] k, input logic we);
    pixe(c, k, rop_exp(c), we);
  endtask
  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rstn = 1'b1;
    `CHK("res_we", 1'b1, res_we)
    rd(WIDTH_OFS, 16'h0000);
    wr(WIDTH_OFS, 16'hfabc);
    rd(WIDTH_OFS, 16'h0abc);
    `CHK("rect_width", 12'habc, rect_width)
    wr(8'h0e, 16'h5555);
    rd(8'h0e, 16'h0000);
    rd(WIDTH_OFS, 16'h0abc);
    wr(ROP_CTRL_OFS, 16'h0800);
    rd(ROP_CTRL_OFS, 16'h0800);
    cmd(CMD_LINE, 12'habc, 12'h000, 1'b0);
    cmd(CMD_SHORT_STROKE, 12'h000, 12'habc, 1'b0);
    cmd(CMD_ROT_BLT, 12'h000, 12'h000, 1'b1);
    cmd(4'h0, 12'h000, 12'h000, 1'b0);
    // packed 24-bit mode: software writes three times the pixel width
    wrrd(WIDTH_OFS, 16'h03ff, 16'h03ff);
    cmd(CMD_LINE, 12'h3ff, 12'h000, 1'b0);
    `CHK("rect_width", 12'h3ff, rect_width)
    wrrd(ROP_CTRL_OFS, 16'h3800, 16'h3800);
    for (int i = 0; i < 256; i++) pix({8'h00, i[7:0]}, K, 1'b1);
    // reserved bits 7:4 held nonzero, they must not disturb two-operand codes
    for (int i = 0; i < 32; i++) pix({1'b1, i[4], 6'h00, 4'ha, i[3:0]}, K, 1'b1);
    pix(16'h05cc, S, 1'b0);
    pix(16'h05cc, D, 1'b1);
    pix(16'h07cc, D, 1'b0);
    pix(16'h01cc, S, 1'b1);
    pix(16'h04cc, S, 1'b1);
    // rotation command with the repeat bit clear must not repeat
    cmd(CMD_ROT_BLT, 12'h000, 12'h000, 1'b0);
    // second operand set, expected values written out from the rules
    pat_pix = D;
    src_pix = P;
    dst_pix = S;
    pixe(16'h00f0, K, D, 1'b1);
    pixe(16'h00cc, K, P, 1'b1);
    pixe(16'h00aa, K, S, 1'b1);
    pixe(16'h8006, K, P ^ S, 1'b1);
    pixe(16'hc00c, K, D, 1'b1);
    pixe(16'h80f1, K, ~(P | S), 1'b1);
    // reset in mid-run: both registers and the write flag go back
    rstn = 1'b0;
    @(posedge clk_sys); #1;
    rstn = 1'b1;
    `CHK("res_we", 1'b1, res_we)
    `CHK("rect_width", 12'h000, rect_width)
    rd(WIDTH_OFS, 16'h0000);
    rd(ROP_CTRL_OFS, 16'h0000);
    test_done();
  end
  // watchdog, well beyond the roughly 1550 cycles the sequence takes
  initial begin
    repeat (6000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
